// File: logic/lcdmpu_pkg.sv
package lcdmpu_pkg;
    localparam int LCDMPU_DW = 8;
    localparam int LCDMPU_CW = 3;
    localparam logic [2:0] LCDMPU_LAST_BIT = 3'h7;
    localparam logic [7:0] LCDMPU_BYTE_RST = 8'h00;
    localparam logic [1:0] LCDMPU_KIND_INSTR = 2'h0;
    localparam logic [1:0] LCDMPU_KIND_STATUS = 2'h1;
    localparam logic [1:0] LCDMPU_KIND_DATA_WR = 2'h2;
    localparam logic [1:0] LCDMPU_KIND_DATA_RD = 2'h3;

    typedef enum logic [1:0] {
        LCDMPU_IDLE = 2'b00,
        LCDMPU_BUSY = 2'b01
    } lcdmpu_state_t;
endpackage

// File: logic/lcdmpu_ser_if.sv
interface lcdmpu_ser_if;
    logic active;
    logic sdata;
    logic sclk_rise;
    logic byte_valid;
    logic [7:0] byte_data;
    modport rx (input active, input sdata, input sclk_rise, output byte_valid, output byte_data);
    modport top (output active, output sdata, output sclk_rise, input byte_valid, input byte_data);
endinterface

// File: logic/lcdmpu_ser_rx.sv
module lcdmpu_ser_rx
    import lcdmpu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    lcdmpu_ser_if.rx ser
);
    logic [7:0] shift;
    logic [LCDMPU_CW-1:0] count;

    always_ff @(posedge i_clk) begin
        if (!i_rst_n || !ser.active) begin
            shift <= LCDMPU_BYTE_RST;
            count <= '0;
        end else if (ser.sclk_rise) begin
            shift <= {shift[6:0], ser.sdata};
            count <= count + 3'h1;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            ser.byte_valid <= 1'b0;
            ser.byte_data <= LCDMPU_BYTE_RST;
        end else begin
            ser.byte_valid <= ser.active && ser.sclk_rise && count == LCDMPU_LAST_BIT;
            if (ser.active && ser.sclk_rise && count == LCDMPU_LAST_BIT) begin
                ser.byte_data <= {shift[6:0], ser.sdata};
            end
        end
    end
endmodule

// File: logic/lcdmpu_top.sv
module lcdmpu_top
    import lcdmpu_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_hw_init_n,
    input wire logic i_parallel_sel,
    input wire logic i_bus_style_select,
    input wire logic i_cs_n,
    input wire logic i_data_command_select,
    input wire logic i_rd,
    input wire logic i_wr,
    input wire logic [7:0] i_d,
    output logic [7:0] o_d,
    output logic o_d_oe,
    input wire logic i_sdata,
    input wire logic i_sclk,
    output logic o_cmd_valid,
    output logic [7:0] o_cmd_data,
    output logic o_mem_wr,
    output logic [7:0] o_mem_wdata,
    output logic o_mem_rd,
    input wire logic [7:0] i_mem_rdata,
    input wire logic [7:0] i_status
);
    // host bus decode
    logic rst;
    logic sel;
    logic par_access;
    logic strobe;
    logic par_strobe;
    logic read_dir;
    logic start;
    lcdmpu_state_t state;
    lcdmpu_state_t next_state;

    // serial path
    logic sclk_q;
    logic ser_dc;
    logic ser_byte;
    lcdmpu_ser_if ser();

    // one strobe per kind of transfer
    logic [1:0] kind;
    logic [1:0] ser_kind;
    logic par_data_rd;
    logic par_data_wr;
    logic par_status;
    logic par_instr;
    logic ser_data_wr;
    logic ser_instr;
    logic data_wr;

    // holding latch
    logic holding_valid;
    logic [7:0] holding;
    logic commit;

    // strobe level for the selected host timing
    function automatic logic strobe_level(input logic style68, input logic rd, input logic wr);
        return style68 ? rd : (!rd || !wr);
    endfunction

    // read direction for the selected host timing
    function automatic logic read_level(input logic style68, input logic rd, input logic wr);
        return style68 ? wr : !rd;
    endfunction

    // transfer kind from data/command level and direction
    function automatic logic [1:0] transfer_kind(input logic dc, input logic dir);
        return {dc, dir};
    endfunction

    assign rst = !i_rst_n || !i_hw_init_n;
    assign sel = !i_cs_n;
    assign par_access = sel && i_parallel_sel;
    // 68: rd pin is enable high, wr pin is direction; 80: low strobes
    assign strobe = strobe_level(i_bus_style_select, i_rd, i_wr);
    assign par_strobe = par_access && strobe;
    assign read_dir = read_level(i_bus_style_select, i_rd, i_wr);
    assign start = par_strobe && state == LCDMPU_IDLE;
    assign ser.active = sel && !i_parallel_sel;
    assign ser.sdata = i_sdata;
    assign ser.sclk_rise = i_sclk && !sclk_q;

    // serial bytes are writes only, parallel strobes win
    assign kind = transfer_kind(i_data_command_select, read_dir);
    assign ser_kind = transfer_kind(ser_dc, 1'b0);
    assign ser_byte = !start && ser.byte_valid;
    assign par_data_rd = start && kind == LCDMPU_KIND_DATA_RD;
    assign par_data_wr = start && kind == LCDMPU_KIND_DATA_WR;
    assign par_status = start && kind == LCDMPU_KIND_STATUS;
    assign par_instr = start && kind == LCDMPU_KIND_INSTR;
    assign ser_data_wr = ser_byte && ser_kind == LCDMPU_KIND_DATA_WR;
    assign ser_instr = ser_byte && ser_kind == LCDMPU_KIND_INSTR;
    assign data_wr = par_data_wr || ser_data_wr;
    assign commit = data_wr && holding_valid;

    lcdmpu_ser_rx u_rx (
        .i_clk(i_clk),
        .i_rst_n(!rst),
        .ser(ser)
    );

    // strobe tracker: one transfer per strobe, a new one needs an idle gap
    always_comb begin
        next_state = state;
        case (state)
            LCDMPU_IDLE: begin
                if (par_strobe) begin
                    next_state = LCDMPU_BUSY;
                end
            end
            LCDMPU_BUSY: begin
                if (!par_strobe) begin
                    next_state = LCDMPU_IDLE;
                end
            end
            default: begin
                next_state = LCDMPU_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (rst) begin
            state <= LCDMPU_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // serial clock edge detector, idle low
    always_ff @(posedge i_clk) begin
        if (rst) begin
            sclk_q <= 1'b0;
        end else begin
            sclk_q <= ser.active && i_sclk;
        end
    end

    // data/command level taken with every serial rising edge
    always_ff @(posedge i_clk) begin
        if (rst) begin
            ser_dc <= 1'b0;
        end else if (ser.active && ser.sclk_rise) begin
            ser_dc <= i_data_command_select;
        end
    end

    // instruction byte towards the decoder
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_cmd_valid <= 1'b0;
            o_cmd_data <= LCDMPU_BYTE_RST;
        end else begin
            o_cmd_valid <= par_instr || ser_instr;
            if (par_instr) begin
                o_cmd_data <= i_d;
            end else if (ser_instr) begin
                o_cmd_data <= ser.byte_data;
            end
        end
    end

    // commit of the byte held from the previous data write
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_mem_wr <= 1'b0;
            o_mem_wdata <= LCDMPU_BYTE_RST;
        end else begin
            o_mem_wr <= commit;
            if (commit) begin
                o_mem_wdata <= holding;
            end
        end
    end

    // fetch request, its answer lands in the holding latch a cycle later
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_mem_rd <= 1'b0;
        end else begin
            o_mem_rd <= par_data_rd;
        end
    end

    // holding latch shared by data writes and pipelined reads
    always_ff @(posedge i_clk) begin
        if (rst) begin
            holding <= LCDMPU_BYTE_RST;
            holding_valid <= 1'b0;
        end else if (par_data_wr) begin
            holding <= i_d;
            holding_valid <= 1'b1;
        end else if (ser_data_wr) begin
            holding <= ser.byte_data;
            holding_valid <= 1'b1;
        end else if (par_data_rd) begin
            holding_valid <= 1'b0;
        end else if (o_mem_rd) begin
            holding <= i_mem_rdata;
        end
    end

    // read data: status, or the holding latch, which holds the last data byte written or the byte fetched by the previous read
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_d <= LCDMPU_BYTE_RST;
        end else if (par_data_rd) begin
            o_d <= holding;
        end else if (par_status) begin
            o_d <= i_status;
        end
    end

    // drive only during a parallel read strobe while selected
    always_ff @(posedge i_clk) begin
        if (rst) begin
            o_d_oe <= 1'b0;
        end else begin
            o_d_oe <= par_strobe && read_dir;
        end
    end
endmodule

// File: sim/lcdmpu_top_asserts.sv
module lcdmpu_top_asserts(input wire logic i_clk, i_rst_n, i_hw_init_n, i_parallel_sel, i_bus_style_select,
    i_cs_n, i_data_command_select, i_rd, i_wr, o_d_oe, o_cmd_valid, o_mem_wr, o_mem_rd,
    input wire logic [7:0] i_status, o_d);
timeunit 1ns;
timeprecision 1ps;
default clocking @(posedge i_clk); endclocking
default disable iff (!i_rst_n);
logic p80;
assign p80 = i_parallel_sel && !i_bus_style_select && !i_cs_n;
sequence cmd80; p80 && !i_data_command_select && $fell(i_wr); endsequence
sequence rd80; p80 && $fell(i_rd); endsequence
cmd80_a: assert property (cmd80 |-> ##[1:2] o_cmd_valid) else $error("no command");
memrd_a: assert property (rd80 ##0 i_data_command_select |-> ##[1:2] o_mem_rd) else $error("no fetch");
stat_a: assert property (rd80 ##0 !i_data_command_select |-> ##[1:2] o_d_oe && o_d == i_status)
    else $error("bad status");
cmd68_a: assert property (i_parallel_sel && i_bus_style_select && !i_cs_n && !i_data_command_select && !i_wr
    && $rose(i_rd) |-> ##[1:2] o_cmd_valid) else $error("no command");
float_a: assert property (i_cs_n && $past(i_cs_n) |-> !o_d_oe) else $error("bus driven");
ignore_a: assert property (i_cs_n [*3] |=> !o_cmd_valid && !o_mem_wr) else $error("not ignored");
serial_a: assert property (!i_parallel_sel && !$past(i_parallel_sel) |-> !o_d_oe && !o_mem_rd)
    else $error("serial read");
init_a: assert property (!i_hw_init_n |=> !o_cmd_valid && !o_mem_wr && !o_d_oe) else $error("init");
endmodule
bind lcdmpu_top lcdmpu_top_asserts u_chk(.i_clk, .i_rst_n, .i_hw_init_n, .i_parallel_sel, .i_bus_style_select,
    .i_cs_n, .i_data_command_select, .i_rd, .i_wr, .o_d_oe, .o_cmd_valid, .o_mem_wr, .o_mem_rd, .i_status, .o_d);

// File: sim/lcdmpu_mem_model.sv
module lcdmpu_mem_model(input wire logic i_clk, input wire logic i_fetch, output logic [7:0] o_rdata);
timeunit 1ns;
timeprecision 1ps;
logic p = 0;
logic [7:0] n = 8'h00;
// pointer moves once a fetch is over
always @(posedge i_clk) p <= i_fetch;
always @(posedge i_clk) if (p && !i_fetch) n <= n + 8'h01;
assign o_rdata = 8'h60 + n;
endmodule

// File: sim/lcd_driver_mpu_interface_test.sv
module lcd_driver_mpu_interface_test;
timeunit 1ns;
timeprecision 1ps;
logic clk = 0, rst_n = 0, init_n = 1, psel = 1, style = 0, cs_n = 1, dc = 0, rd = 1, wr = 1, sd = 0, sck = 0;
logic [7:0] d = 8'h00, od, cd, wd, rdt, lcd, lwd, rv, n;
logic oe, cv, mw, mr, ro;
logic [7:0] nmw = 8'h00, st = 8'h5c;
int bad_count = 0, check_count = 0;
initial forever #2 clk = ~clk;
lcdmpu_mem_model mem(.i_clk(clk), .i_fetch(mr), .o_rdata(rdt));
lcdmpu_top dut(.i_clk(clk), .i_rst_n(rst_n), .i_hw_init_n(init_n), .i_parallel_sel(psel), .i_bus_style_select(style),
    .i_cs_n(cs_n), .i_data_command_select(dc), .i_rd(rd), .i_wr(wr), .i_d(d), .o_d(od), .o_d_oe(oe), .i_sdata(sd),
    .i_sclk(sck), .o_cmd_valid(cv), .o_cmd_data(cd), .o_mem_wr(mw), .o_mem_wdata(wd), .o_mem_rd(mr),
    .i_mem_rdata(rdt), .i_status(st));
always @(posedge clk) if (cv === 1'b1) lcd <= cd;
always @(posedge clk) if (mw === 1'b1) lwd <= wd;
always @(posedge clk) if (mw === 1'b1) nmw <= nmw + 8'h01;
task chk(input logic [7:0] s, e);
    check_count++;
    if (s !== e) begin
        bad_count++;
        $display("Error %0t: got %h want %h", $time, s, e);
    end
endtask
task complete_run;
    $display("checks %0d errors %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
endtask
task cyc(input int k);
    repeat (k) @(negedge clk);
endtask
task xfer(input logic s68, c, r, input logic [7:0] v);
    style = s68;
    dc = c;
    d = v;
    cs_n = 0;
    rd = !s68;
    wr = s68 ? r : 1'b1;
    cyc(1);
    if (s68) rd = 1;
    else if (r) rd = 0;
    else wr = 0;
    cyc(4);
    rv = od;
    ro = oe;
    rd = !s68;
    wr = 1;
    cs_n = 1;
    cyc(4);
endtask
task ser(input int k, input logic c, input logic [7:0] v);
    psel = 0;
    dc = c;
    cs_n = 0;
    cyc(1);
    for (int i = 7; i > 7 - k; i--) begin
        sd = v[i];
        cyc(2);
        sck = 1;
        cyc(2);
        sck = 0;
    end
    cyc(4);
    cs_n = 1;
    sd = ~sd;
    cyc(2);
    psel = 1;
endtask
task t80;
    xfer(0, 0, 0, 8'h3c);
    chk(lcd, 8'h3c);
    xfer(0, 1, 0, 8'h11);
    xfer(0, 1, 0, 8'h22);
    chk(lwd, 8'h11);
    chk({7'h00, ro}, 8'h00);
    xfer(0, 0, 1, 8'h00);
    chk(rv, 8'h5c);
    chk({7'h00, ro}, 8'h01);
    xfer(0, 1, 1, 8'h00);
    xfer(0, 1, 1, 8'h00);
    chk(rv, 8'h60);
endtask
task tcs;
    d = 8'h99;
    rd = 0;
    wr = 0;
    cyc(3);
    chk({7'h00, oe}, 8'h00);
    rd = 1;
    wr = 1;
    cyc(3);
    chk(lcd, 8'h3c);
endtask
task tinit;
    xfer(0, 1, 0, 8'h33);
    init_n = 0;
    cyc(1);
    init_n = 1;
    n = nmw;
    xfer(0, 1, 0, 8'h44);
    chk(nmw, n);
endtask
task tser;
    ser(8, 0, 8'ha5);
    chk(lcd, 8'ha5);
    ser(3, 0, 8'hff);
    ser(8, 0, 8'h5a);
    chk(lcd, 8'h5a);
    ser(8, 1, 8'h77);
    ser(8, 1, 8'h88);
    chk(lwd, 8'h77);
endtask
task t68;
    xfer(1, 0, 0, 8'hc3);
    chk(lcd, 8'hc3);
    st = 8'ha7;
    xfer(1, 0, 1, 8'h00);
    chk(rv, 8'ha7);
    chk({7'h00, ro}, 8'h01);
endtask
initial begin
    cyc(16);
    rst_n = 1;
    cyc(2);
    t80;
    tcs;
    tinit;
    tser;
    t68;
    complete_run;
end
initial begin
    #20000;
    bad_count++;
    complete_run;
end
endmodule
